// ---- core/cmg_pkg.sv ----
// Purpose: Shared constants and types for the carriage motor gate logic
// Assumes: 50 MHz sys_clk
// Notes:   All counts are in sys_clk cycles
package cmg_pkg;

	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned POS_W        = 8;
	localparam int unsigned DUTY_W       = 8;
	localparam int unsigned PAR_W        = 8;
	localparam int unsigned CHANNELS     = 2;

	// PWM period is the full span of the duty counter
	localparam int unsigned PWM_PERIOD   = 256;
	localparam logic [7:0]  PWM_CNT_LAST = 8'h00FF;

	// Reset values
	localparam logic [7:0]  POS_RESET    = 8'h0000;
	localparam logic [7:0]  DUTY_RESET   = 8'h0000;

	// Parallel acknowledge pulse width
	localparam int unsigned ACK_NS       = 500;
	localparam int unsigned ACK_CYCLES   =
		(ACK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [7:0]  ACK_LAST     = 8'(ACK_CYCLES - 1);

	// Idle cycles forced between polarity reversals of a bridge
	localparam int unsigned DEAD_NS      = 100;
	localparam int unsigned DEAD_CYCLES  =
		(DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [3:0]  DEAD_LAST    = 4'(DEAD_CYCLES - 1);

	typedef enum logic [3:0] {
		CMG_DMA_IDLE = 4'b0001,
		CMG_DMA_REQ  = 4'b0010,
		CMG_DMA_ACK  = 4'b0100,
		CMG_DMA_REL  = 4'b1000
	} cmg_dma_state_t;

	typedef enum logic [2:0] {
		CMG_CH_OFF  = 3'b001,
		CMG_CH_DEAD = 3'b010,
		CMG_CH_RUN  = 3'b100
	} cmg_ch_state_t;

endpackage

// ---- core/cmg_chop_if.sv ----
// Purpose: Carrier between the top and one winding current channel
// Assumes: One instance per winding
// Notes:   Bridge outputs are registered in the channel
interface cmg_chop_if;
	logic enable;
	logic pol;
	logic cur_low;
	logic hi_a;
	logic lo_a;
	logic hi_b;
	logic lo_b;

	modport chan (
		input  enable,
		input  pol,
		input  cur_low,
		output hi_a,
		output lo_a,
		output hi_b,
		output lo_b
	);

	modport ctrl (
		output enable,
		output pol,
		output cur_low,
		input  hi_a,
		input  lo_a,
		input  hi_b,
		input  lo_b
	);
endinterface

// ---- core/cmg_chop_chan.sv ----
// Purpose: Current chopper and H-bridge control for one stepper winding
// Assumes: Comparator level is synchronous to sys_clk
// Notes:   Polarity change passes through a dead-time state
module cmg_chop_chan
	import cmg_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst_n,
	cmg_chop_if.chan ch
);

	cmg_ch_state_t state;
	logic [3:0]    dead_cnt;
	logic          run_pol;
	logic          pulse_on;

	// Sequencing of off, dead time and run
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= CMG_CH_OFF;
			dead_cnt <= 4'h0000;
			run_pol  <= 1'b0;
		end else begin
			case (state)
				CMG_CH_OFF: begin
					if (ch.enable) begin
						state    <= CMG_CH_DEAD;
						dead_cnt <= 4'h0000;
						run_pol  <= ch.pol;
					end
				end
				CMG_CH_DEAD: begin
					if (!ch.enable) begin
						state <= CMG_CH_OFF;
					end else if (dead_cnt == DEAD_LAST) begin
						state <= CMG_CH_RUN;
					end else begin
						dead_cnt <= dead_cnt + 4'h0001;
					end
				end
				CMG_CH_RUN: begin
					if (!ch.enable) begin
						state <= CMG_CH_OFF;
					end else if (ch.pol != run_pol) begin
						state    <= CMG_CH_DEAD;
						dead_cnt <= 4'h0000;
						run_pol  <= ch.pol;
					end
				end
				default: begin
					state <= CMG_CH_OFF;
				end
			endcase
		end
	end

	// Pulse on while current is below reference, off once above
	assign pulse_on = (state == CMG_CH_RUN) && ch.cur_low;

	// Either diagonal of the bridge drives the winding
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ch.hi_a <= 1'b0;
			ch.lo_a <= 1'b0;
			ch.hi_b <= 1'b0;
			ch.lo_b <= 1'b0;
		end else begin
			ch.hi_a <= pulse_on && !run_pol;
			ch.lo_b <= pulse_on && !run_pol;
			ch.hi_b <= pulse_on && run_pol;
			ch.lo_a <= pulse_on && run_pol;
		end
	end

endmodule

// ---- core/cmg_top.sv ----
// Purpose: Carriage encoder counter, servo PWM, winding choppers, DMA strobes
// Assumes: All inputs synchronous to sys_clk
// Notes:   Position counter is relative; firmware keeps absolute position
module cmg_top
	import cmg_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic              enc_a,
	input  wire logic              enc_b,
	input  wire logic              res_300,
	input  wire logic              dir_left,
	output logic      [POS_W-1:0]  pos_count,
	input  wire logic [DUTY_W-1:0] duty_wdata,
	input  wire logic              duty_we,
	output logic      [DUTY_W-1:0] duty_value,
	output logic                   servo_pwm,
	input  wire logic [1:0]        wind_enable,
	input  wire logic [1:0]        wind_pol,
	input  wire logic [1:0]        wind_cur_low,
	output logic      [1:0]        wind_hi_a,
	output logic      [1:0]        wind_lo_a,
	output logic      [1:0]        wind_hi_b,
	output logic      [1:0]        wind_lo_b,
	input  wire logic              par_strobe_b,
	input  wire logic [PAR_W-1:0]  par_data,
	input  wire logic              dma_ack,
	output logic                   dma_req,
	output logic      [PAR_W-1:0]  dma_data,
	output logic                   par_busy,
	output logic                   par_ack_b
);

	logic           rst_q1;
	logic           rst_n;
	logic           a_prev;
	logic           b_prev;
	logic           a_edge;
	logic           b_edge;
	logic           step;
	logic           step_up;
	logic           full_step;
	logic           full_up;
	logic           half_step;
	logic           half_up;
	logic [7:0]     pwm_cnt;
	logic [7:0]     duty_active;
	logic           period_end;
	logic           next_servo_pwm;
	logic           strobe_prev;
	logic [7:0]     ack_cnt;
	logic           strobe_fall;
	logic           take_byte;
	logic           ack_seen;
	logic           ack_done;
	logic           host_let_go;
	cmg_dma_state_t dma_state;

	// Reset release through two flip-flops
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end

	// Previous encoder levels for edge detection
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			a_prev <= 1'b0;
			b_prev <= 1'b0;
		end else begin
			a_prev <= enc_a;
			b_prev <= enc_b;
		end
	end

	assign a_edge = enc_a ^ a_prev;
	assign b_edge = enc_b ^ b_prev;

	// Full resolution decode; simultaneous edges on both channels are dropped
	always_comb begin
		full_step = 1'b0;
		full_up   = 1'b0;
		if (a_edge && !b_edge) begin
			full_step = 1'b1;
			full_up   = enc_a ^ enc_b;
		end else if (b_edge && !a_edge) begin
			full_step = 1'b1;
			full_up   = ~(enc_a ^ enc_b);
		end
	end

	// Half resolution decode from channel A only
	always_comb begin
		half_step = a_edge;
		half_up   = dir_left;
	end

	// Resolution select
	always_comb begin
		if (res_300) begin
			step    = half_step;
			step_up = half_up;
		end else begin
			step    = full_step;
			step_up = full_up;
		end
	end

	// Relative position counter, wraps in both directions
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_count <= POS_RESET;
		end else if (step) begin
			if (step_up) begin
				pos_count <= pos_count + 8'h0001;
			end else begin
				pos_count <= pos_count - 8'h0001;
			end
		end
	end
	// pos_count is an 8-bit register read at will by firmware

	// Duty value as written by firmware
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			duty_value <= DUTY_RESET;
		end else if (duty_we) begin
			duty_value <= duty_wdata;
		end
	end

	// Last cycle of the fixed period
	assign period_end = (pwm_cnt == PWM_CNT_LAST);

	// Fixed period counter; duty taken up at each period start
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_cnt     <= 8'h0000;
			duty_active <= DUTY_RESET;
		end else begin
			pwm_cnt <= pwm_cnt + 8'h0001;
			if (period_end) begin
				duty_active <= duty_value;
			end
		end
	end

	// Level of the servo drive for the coming cycle
	always_comb begin
		if (period_end) begin
			next_servo_pwm = (duty_value != 8'h0000);
		end else begin
			next_servo_pwm = ((pwm_cnt + 8'h0001) < duty_active);
		end
	end

	// Servo drive high for duty_active cycles of each period
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			servo_pwm <= 1'b0;
		end else begin
			servo_pwm <= next_servo_pwm;
		end
	end

	// Winding current channels
	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
			cmg_chop_if chop ();

			assign chop.enable  = wind_enable[gi];
			assign chop.pol     = wind_pol[gi];
			assign chop.cur_low = wind_cur_low[gi];
			assign wind_hi_a[gi] = chop.hi_a;
			assign wind_lo_a[gi] = chop.lo_a;
			assign wind_hi_b[gi] = chop.hi_b;
			assign wind_lo_b[gi] = chop.lo_b;

			cmg_chop_chan u_chan (
				.sys_clk (sys_clk),
				.rst_n   (rst_n),
				.ch      (chop.chan)
			);
		end
	endgenerate

	// Parallel strobe history
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_prev <= 1'b1;
		end else begin
			strobe_prev <= par_strobe_b;
		end
	end

	// Handshake events; all but strobe_fall tied to the state that honours them
	assign strobe_fall = strobe_prev && !par_strobe_b;
	assign take_byte   = (dma_state == CMG_DMA_IDLE) && strobe_fall;
	assign ack_seen    = (dma_state == CMG_DMA_REQ) && dma_ack;
	assign ack_done    = (dma_state == CMG_DMA_ACK) && (ack_cnt == ACK_LAST);
	assign host_let_go = (dma_state == CMG_DMA_REL) && par_strobe_b;

	// Parallel byte to DMA handshake sequencing
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dma_state <= CMG_DMA_IDLE;
		end else begin
			case (dma_state)
				CMG_DMA_IDLE: begin
					if (take_byte) begin
						dma_state <= CMG_DMA_REQ;
					end
				end
				CMG_DMA_REQ: begin
					if (ack_seen) begin
						dma_state <= CMG_DMA_ACK;
					end
				end
				CMG_DMA_ACK: begin
					if (ack_done) begin
						dma_state <= CMG_DMA_REL;
					end
				end
				CMG_DMA_REL: begin
					if (host_let_go) begin
						dma_state <= CMG_DMA_IDLE;
					end
				end
				default: begin
					dma_state <= CMG_DMA_IDLE;
				end
			endcase
		end
	end

	// Byte latched at the strobe
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dma_data <= '0;
		end else if (take_byte) begin
			dma_data <= par_data;
		end
	end

	// DMA request from the strobe until acknowledged
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dma_req <= 1'b0;
		end else if (take_byte) begin
			dma_req <= 1'b1;
		end else if (ack_seen) begin
			dma_req <= 1'b0;
		end
	end

	// Acknowledge pulse length
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_cnt <= 8'h0000;
		end else if (dma_state == CMG_DMA_ACK) begin
			ack_cnt <= ack_cnt + 8'h0001;
		end else begin
			ack_cnt <= 8'h0000;
		end
	end

	// Acknowledge back to the host, low for the pulse length
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			par_ack_b <= 1'b1;
		end else if (ack_seen) begin
			par_ack_b <= 1'b0;
		end else if (ack_done) begin
			par_ack_b <= 1'b1;
		end
	end

	// Busy from the strobe until the host lets the strobe go
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			par_busy <= 1'b0;
		end else if (take_byte) begin
			par_busy <= 1'b1;
		end else if (host_let_go) begin
			par_busy <= 1'b0;
		end
	end

endmodule

// ---- dv/cmg_top_assertions.sv ----
// Purpose: Port checks for cmg_top
// Assumes: Bound into every cmg_top
// Notes:   Checks other than chk_bridge_safe wait three edges after reset release
module cmg_top_chk
	import cmg_pkg::*;
(
	input wire logic		sys_clk,
	input wire logic		rst_b,
	input wire logic		enc_a,
	input wire logic		enc_b,
	input wire logic		res_300,
	input wire logic		dir_left,
	input wire logic [7:0]	pos_count,
	input wire logic [7:0]	duty_wdata,
	input wire logic		duty_we,
	input wire logic [7:0]	duty_value,
	input wire logic [1:0]	wind_enable,
	input wire logic [1:0]	wind_pol,
	input wire logic [1:0]	wind_cur_low,
	input wire logic [1:0]	wind_hi_a,
	input wire logic [1:0]	wind_lo_a,
	input wire logic [1:0]	wind_hi_b,
	input wire logic [1:0]	wind_lo_b
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	chk_a_up: assert property ($past(rst_b, 3) && !res_300
		&& $changed(enc_a) && $stable(enc_b) && enc_a != enc_b
		|=> pos_count == $past(pos_count) + 8'h01) else $error("no up");
	chk_a_down: assert property ($past(rst_b, 3) && !res_300
		&& $changed(enc_a) && $stable(enc_b) && enc_a == enc_b
		|=> pos_count == $past(pos_count) + 8'hFF) else $error("no down");
	chk_b_down: assert property ($past(rst_b, 3) && !res_300
		&& $changed(enc_b) && $stable(enc_a) && enc_a != enc_b
		|=> pos_count == $past(pos_count) + 8'hFF) else $error("b step");
	chk_pos_hold: assert property ($past(rst_b, 3) && $stable(enc_a)
		&& (res_300 || $stable(enc_b)) |=> $stable(pos_count))
		else $error("stray count");
	chk_half_left: assert property ($past(rst_b, 3) && res_300
		&& dir_left && $changed(enc_a)
		|=> pos_count == $past(pos_count) + 8'h01) else $error("half");
	chk_duty_load: assert property ($past(rst_b, 3) && duty_we
		|=> duty_value == $past(duty_wdata)) else $error("duty");
	chk_bridge_safe: assert property (((wind_hi_a & wind_lo_a)
		| (wind_hi_b & wind_lo_b)) == 2'h0) else $error("shoot");
	chk_chop_drive: assert property (($past(rst_b, 3)
		&& wind_enable[0] && !wind_pol[0] && wind_cur_low[0]) [*8]
		|=> wind_hi_a[0] && wind_lo_b[0]) else $error("no drive");
endmodule
bind cmg_top cmg_top_chk i_cmg_top_chk (.*);

// ---- dv/cmg_dma_host.sv ----
// Purpose: DMA controller model answering cmg_top requests
// Assumes: Request held until acknowledged
// Notes:   lag sets the answer delay in cycles
module cmg_dma_host (
	input  wire logic		clk,
	input  wire logic		req,
	input  wire logic [7:0]	data,
	input  wire logic [3:0]	lag,
	output logic			ack,
	output logic [7:0]		got
);
	timeunit 1ns;
	timeprecision 1ns;
	logic	[3:0]	wait_n;
	initial begin
		ack = 1'b0;
		got = 8'h00;
		wait_n = 4'h0;
	end
	always @(posedge clk) begin
		if (!req) begin
			ack <= 1'b0;
			wait_n <= 4'h0;
		end else if (!ack && wait_n == lag) begin
			ack <= 1'b1;
			got <= data;
		end else if (!ack)
			wait_n <= wait_n + 4'h1;
	end
endmodule

// ---- dv/tb_carriage_motor_gate_logic.sv ----
// Purpose: Self-checking bench for carriage motor gate logic
// Assumes: Inputs change on the falling edge
// Notes:   cmg_dma_host answers DMA requests
module tb_carriage_motor_gate_logic
	import cmg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic		sys_clk, rst_b, enc_a, enc_b, res_300, dir_left;
	logic		duty_we, servo_pwm, dma_ack, dma_req, par_busy;
	logic		par_ack_b, par_strobe_b;
	logic [7:0]	pos_count, duty_wdata, duty_value, par_data, dma_data, got;
	logic [1:0]	wind_enable, wind_pol, wind_cur_low;
	logic [1:0]	wind_hi_a, wind_lo_a, wind_hi_b, wind_lo_b;
	logic [3:0]	lag;
	wire [2:0]	flags = {par_busy, par_ack_b, dma_req};
	int			bad_count, n_compared;
	cmg_top i_cmg_top (.*);
	cmg_dma_host i_cmg_dma_host (.clk(sys_clk), .req(dma_req),
		.data(dma_data), .lag(lag), .ack(dma_ack), .got(got));
	always #10 sys_clk = ~sys_clk;
	task automatic complete_run();
		$display("compared %0d errors %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic wait_for(input int s, input logic v);
		int i;
		for (i = 0; i < 2000 && flags[s] !== v; i++)
			tick(1);
		if (i == 2000) begin
			bad_count++;
			$display("[ERR] %0t wait timed out", $time);
			complete_run();
		end
	endtask
	function automatic logic [7:0] br(int w);
		return 8'({wind_hi_a[w], wind_lo_a[w], wind_hi_b[w], wind_lo_b[w]});
	endfunction
	task automatic enc(input logic [1:0] ab, input logic [7:0] e);
		{enc_a, enc_b} = ab;
		tick(3);
		cmp(pos_count, e);
	endtask
	task automatic t_full();
		enc(2'b01, 8'hFF);
		enc(2'b11, 8'hFE);
		enc(2'b10, 8'hFD);
		enc(2'b00, 8'hFC);
		enc(2'b10, 8'hFD);
		enc(2'b11, 8'hFE);
		enc(2'b01, 8'hFF);
		enc(2'b00, 8'h00);
		enc(2'b11, 8'h00);
		enc(2'b00, 8'h00);
	endtask
	task automatic t_half();
		res_300 = 1;
		dir_left = 1;
		enc(2'b01, 8'h00);
		enc(2'b11, 8'h01);
		dir_left = 0;
		enc(2'b01, 8'h00);
		enc(2'b00, 8'h00);
		res_300 = 0;
	endtask
	task automatic t_servo();
		logic [7:0] last;
		int absolute;
		last = pos_count;
		absolute = 0;
		repeat (3) begin
			repeat (100) begin
				{enc_a, enc_b} = {~enc_b, enc_a};
				tick(2);
			end
			cmp(8'(pos_count - last), 8'h64);
			absolute += int'(signed'(8'(pos_count - last)));
			last = pos_count;
		end
		cmp(8'(absolute >> 2), 8'h4B);
	endtask
	task automatic t_duty();
		int n;
		logic [7:0] d [3] = '{8'h0A, 8'h00, 8'hFF};
		foreach (d[k]) begin
			duty_wdata = d[k];
			duty_we = 1;
			tick(1);
			duty_we = 0;
			tick(1);
			cmp(duty_value, d[k]);
			tick(300);
			n = 0;
			repeat (256) begin
				if (servo_pwm === 1'b1)
					n++;
				tick(1);
			end
			cmp(8'(n), d[k]);
		end
	endtask
	task automatic t_wind();
		for (int w = 0; w < 2; w++)
			for (int p = 0; p < 2; p++) begin
				wind_pol[w] = p[0];
				wind_cur_low[w] = 1;
				wind_enable[w] = 1;
				tick(10);
				cmp(br(w), p ? 8'h06 : 8'h09);
				cmp(br(1 - w), 8'h00);
				wind_cur_low[w] = 0;
				tick(3);
				cmp(br(w), 8'h00);
				wind_enable[w] = 0;
				tick(3);
			end
	endtask
	task automatic t_dma(input logic [3:0] l, input logic [7:0] v);
		int n;
		lag = l;
		par_data = v;
		par_strobe_b = 0;
		wait_for(0, 1);
		cmp(dma_data, v);
		wait_for(1, 0);
		cmp(got, v);
		for (n = 0; n < 99 && par_ack_b === 1'b0; n++)
			tick(1);
		cmp(8'(n), 8'(ACK_CYCLES));
		par_strobe_b = 1;
		wait_for(2, 0);
		cmp(8'(dma_req), 8'h00);
	endtask
	initial begin
		{sys_clk, rst_b, enc_a, enc_b, res_300, dir_left, duty_we} = '0;
		{wind_enable, wind_pol, wind_cur_low, lag} = '0;
		duty_wdata = 8'h00;
		par_data = 8'h00;
		par_strobe_b = 1;
		bad_count = 0;
		n_compared = 0;
		tick(8);
		rst_b = 1;
		tick(4);
		t_full();
		t_half();
		t_servo();
		t_duty();
		t_wind();
		t_dma(4'h0, 8'hA5);
		t_dma(4'h7, 8'h3C);
		complete_run();
	end
endmodule
